// ---- verilog/hs_timer_pkg.sv ----
package hs_timer_pkg;
    // ==========================================
    // register offsets
    localparam logic [6:0] timer_cfg_addr = 7'h0d;
    localparam logic [6:0] shutdown_addr = 7'h10;
    localparam logic [6:0] switch_src_addr = 7'h14;
    localparam logic [6:0] fault_status_addr = 7'h70;

    // ==========================================
    // field layout
    localparam int on_lsb = 4;
    localparam int per_lsb = 0;
    localparam int ov_dis_bit = 6;
    localparam int uv_dis_bit = 5;
    localparam int rec_bit = 4;
    localparam int sw_a_lsb = 0;
    localparam int sw_b_lsb = 4;
    localparam logic [7:0] timer_cfg_mask = 8'h77;
    localparam logic [7:0] shutdown_mask = 8'h70;
    localparam logic [7:0] switch_src_mask = 8'h77;
    localparam logic [7:0] reset_value = 8'h00;

    // ==========================================
    // encodings
    localparam logic [2:0] on_low = 3'h0;
    localparam logic [2:0] on_high = 3'h6;
    localparam logic [2:0] on_reserved = 3'h7;
    localparam logic [2:0] per_reserved = 3'h7;
    localparam logic [2:0] src_off = 3'h0;
    localparam logic [2:0] src_on = 3'h1;
    localparam logic [2:0] src_first_timer = 3'h2;
    localparam logic [2:0] src_second_timer = 3'h3;
    localparam logic [2:0] src_first_duty = 3'h4;
    localparam logic [2:0] src_second_duty = 3'h5;

    // ==========================================
    // timing
    localparam int clk_hz = 20_000_000;
    localparam int tick_us = 100;
    localparam int tick_cycles = clk_hz / 1_000_000 * tick_us;
    localparam int filter_us = 16;
    localparam int filter_cycles = (clk_hz / 1_000_000 * filter_us);
    // on-time in 0.1 ms ticks, codes 1..5
    localparam logic [15:0] on_ticks_1 = 16'h0001;
    localparam logic [15:0] on_ticks_2 = 16'h0003;
    localparam logic [15:0] on_ticks_3 = 16'h000a;
    localparam logic [15:0] on_ticks_4 = 16'h0064;
    localparam logic [15:0] on_ticks_5 = 16'h00c8;
    // period in 0.1 ms ticks, codes 0..6
    localparam logic [15:0] per_ticks_0 = 16'h0064;
    localparam logic [15:0] per_ticks_1 = 16'h00c8;
    localparam logic [15:0] per_ticks_2 = 16'h01f4;
    localparam logic [15:0] per_ticks_3 = 16'h03e8;
    localparam logic [15:0] per_ticks_4 = 16'h07d0;
    localparam logic [15:0] per_ticks_5 = 16'h2710;
    localparam logic [15:0] per_ticks_6 = 16'h4e20;
endpackage

// ---- verilog/tick_divider.sv ----
`timescale 1ns/1ns
module tick_divider #(
    parameter int divide = 2000
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic clear_in,
    output logic tick_out
);
    logic [15:0] count_reg;

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            count_reg <= 16'h0000;
            tick_out <= 1'b0;
        end else if (clear_in || count_reg == 16'(divide - 1)) begin
            count_reg <= 16'h0000;
            tick_out <= !clear_in;
        end else begin
            count_reg <= count_reg + 16'h0001;
            tick_out <= 1'b0;
        end
    end
endmodule

// ---- verilog/wake_filter.sv ----
`timescale 1ns/1ns
module wake_filter #(
    parameter int filter_cycles = 320
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic sample_in,
    input wire logic level_in,
    output logic wake_out
);
    logic [15:0] count_reg;
    logic busy_reg;

    // level must hold for the filter time after the on-time ends
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            count_reg <= 16'h0000;
            busy_reg <= 1'b0;
            wake_out <= 1'b0;
        end else if (sample_in) begin
            count_reg <= 16'h0000;
            busy_reg <= 1'b1;
            wake_out <= 1'b0;
        end else if (busy_reg) begin
            if (!level_in) begin
                busy_reg <= 1'b0;
                wake_out <= 1'b0;
            end else if (count_reg == 16'(filter_cycles - 1)) begin
                busy_reg <= 1'b0;
                wake_out <= 1'b1;
            end else begin
                count_reg <= count_reg + 16'h0001;
                wake_out <= 1'b0;
            end
        end else begin
            wake_out <= 1'b0;
        end
    end
endmodule

// ---- verilog/hs_timer_ctrl.sv ----
`timescale 1ns/1ns
// Functional notes
// - on-time codes 1 to 5 select 0.1, 0.3, 1, 10 and 20 ms; code 7 is reserved.
// - on-time code 0 stops the timer and drives its switches low.
// - on-time code 6 stops the timer and drives its switches high.
// - period codes 0 to 6 select 10, 20, 50, 100, 200 ms, 1 s and 2 s; code 7 is reserved.
// - once a switch is assigned, writing a running on-time code starts the timer.
// - in restart with cyclic sensing and switches cleared, the timer settings also clear.
// - reserved bits ignore writes and read as zero.
// - shutdown bit 6 at one suppresses switch shutdown on rail overvoltage.
// - shutdown bit 5 at one suppresses switch shutdown on rail undervoltage.
// - shutdown bit 4 at one restores switches after the rail fault clears, else they stay off.
// - each switch source field selects off, on, timer 1, timer 2, duty 1 or duty 2.
// - overcurrent or overtemperature on a switch clears its source field.
// - timer and switch registers are zero after reset, soft reset and restart entry.
// - a wake input in option D samples at the end of timer 2 on-time with a 16 us filter.
module hs_timer_ctrl (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic [6:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [7:0] rdata_out,
    input wire logic soft_reset_in,
    input wire logic restart_entry_in,
    input wire logic cyclic_sense_in,
    input wire logic first_timer_in,
    input wire logic first_duty_in,
    input wire logic second_duty_in,
    input wire logic [1:0] overcurrent_in,
    input wire logic [1:0] overtemp_in,
    input wire logic rail_ov_in,
    input wire logic rail_uv_in,
    input wire logic wake_option_d_in,
    input wire logic wake_level_in,
    output logic [1:0] switch_output_out,
    output logic timer_running_out,
    output logic wake_event_out
);
    // ==========================================
    // synchronisers for pin inputs
    logic [7:0] pin_meta_reg;
    logic [7:0] pin_sync_reg;

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pin_meta_reg <= 8'h00;
            pin_sync_reg <= 8'h00;
        end else begin
            pin_meta_reg <= {overcurrent_in, overtemp_in, rail_ov_in, rail_uv_in,
                wake_level_in, 1'b0};
            pin_sync_reg <= pin_meta_reg;
        end
    end

    logic [1:0] oc_sync;
    logic [1:0] ot_sync;
    logic ov_sync;
    logic uv_sync;
    logic wake_sync;
    assign oc_sync = pin_sync_reg[7:6];
    assign ot_sync = pin_sync_reg[5:4];
    assign ov_sync = pin_sync_reg[3];
    assign uv_sync = pin_sync_reg[2];
    assign wake_sync = pin_sync_reg[1];

    // ==========================================
    // registers
    logic [7:0] timer_cfg_reg;
    logic [7:0] shutdown_reg;
    logic [7:0] switch_src_reg;
    logic [2:0] on_code;
    logic [2:0] per_code;
    logic [1:0] clear_sw;
    logic wr_timer;
    logic wr_shut;
    logic wr_sw;
    logic wipe;

    assign on_code = timer_cfg_reg[hs_timer_pkg::on_lsb +: 3];
    assign per_code = timer_cfg_reg[hs_timer_pkg::per_lsb +: 3];
    assign wr_timer = wr_in && addr_in == hs_timer_pkg::timer_cfg_addr;
    assign wr_shut = wr_in && addr_in == hs_timer_pkg::shutdown_addr;
    assign wr_sw = wr_in && addr_in == hs_timer_pkg::switch_src_addr;
    assign clear_sw = oc_sync | ot_sync;
    assign wipe = soft_reset_in || restart_entry_in;

    function automatic logic uses_second_timer(input logic [7:0] src);
        uses_second_timer =
            src[hs_timer_pkg::sw_a_lsb +: 3] == hs_timer_pkg::src_second_timer ||
            src[hs_timer_pkg::sw_b_lsb +: 3] == hs_timer_pkg::src_second_timer;
    endfunction

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            timer_cfg_reg <= hs_timer_pkg::reset_value;
        end else if (wipe) begin
            timer_cfg_reg <= hs_timer_pkg::reset_value;
        end else if (wr_timer) begin
            timer_cfg_reg <= wdata_in & hs_timer_pkg::timer_cfg_mask;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            shutdown_reg <= hs_timer_pkg::reset_value;
        end else if (soft_reset_in) begin
            shutdown_reg <= hs_timer_pkg::reset_value;
        end else if (wr_shut) begin
            shutdown_reg <= wdata_in & hs_timer_pkg::shutdown_mask;
        end
    end

    // fault clear wins over a same-cycle write
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            switch_src_reg <= hs_timer_pkg::reset_value;
        end else if (wipe) begin
            switch_src_reg <= hs_timer_pkg::reset_value;
        end else begin
            switch_src_reg <= (wr_sw ? wdata_in & hs_timer_pkg::switch_src_mask
                : switch_src_reg) & ~{1'b0, {3{clear_sw[1]}}, 1'b0, {3{clear_sw[0]}}};
        end
    end

    // ==========================================
    // register read
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rdata_out <= 8'h00;
        end else if (rd_in) begin
            unique case (addr_in)
                hs_timer_pkg::timer_cfg_addr: rdata_out <= timer_cfg_reg;
                hs_timer_pkg::shutdown_addr: rdata_out <= shutdown_reg;
                hs_timer_pkg::switch_src_addr: rdata_out <= switch_src_reg;
                hs_timer_pkg::fault_status_addr:
                    rdata_out <= {2'h0, ov_sync, uv_sync, oc_sync, ot_sync};
                default: rdata_out <= 8'h00;
            endcase
        end else begin
            rdata_out <= 8'h00;
        end
    end

    // ==========================================
    // second cyclic timer
    logic tick;
    logic running;
    logic [15:0] tick_count_reg;
    logic [15:0] on_ticks;
    logic [15:0] per_ticks;
    logic timer_level_reg;
    logic on_end_reg;

    always_comb begin
        unique case (on_code)
            3'h1: on_ticks = hs_timer_pkg::on_ticks_1;
            3'h2: on_ticks = hs_timer_pkg::on_ticks_2;
            3'h3: on_ticks = hs_timer_pkg::on_ticks_3;
            3'h4: on_ticks = hs_timer_pkg::on_ticks_4;
            3'h5: on_ticks = hs_timer_pkg::on_ticks_5;
            default: on_ticks = 16'h0000;
        endcase
        unique case (per_code)
            3'h0: per_ticks = hs_timer_pkg::per_ticks_0;
            3'h1: per_ticks = hs_timer_pkg::per_ticks_1;
            3'h2: per_ticks = hs_timer_pkg::per_ticks_2;
            3'h3: per_ticks = hs_timer_pkg::per_ticks_3;
            3'h4: per_ticks = hs_timer_pkg::per_ticks_4;
            3'h5: per_ticks = hs_timer_pkg::per_ticks_5;
            3'h6: per_ticks = hs_timer_pkg::per_ticks_6;
            default: per_ticks = 16'h0000;
        endcase
    end

    // runs only with a running on-time, a valid period and an assigned switch
    assign running = on_ticks != 16'h0000 && per_code != hs_timer_pkg::per_reserved &&
        uses_second_timer(switch_src_reg);

    tick_divider #(
        .divide(hs_timer_pkg::tick_cycles)
    ) u_tick (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .clear_in(!running),
        .tick_out(tick)
    );

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            tick_count_reg <= 16'h0000;
        end else if (!running) begin
            tick_count_reg <= 16'h0000;
        end else if (tick) begin
            tick_count_reg <= (tick_count_reg >= per_ticks - 16'h0001) ? 16'h0000
                : tick_count_reg + 16'h0001;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            timer_level_reg <= 1'b0;
            on_end_reg <= 1'b0;
        end else begin
            if (on_code == hs_timer_pkg::on_high) begin
                timer_level_reg <= 1'b1;
            end else if (!running) begin
                timer_level_reg <= 1'b0;
            end else begin
                timer_level_reg <= tick_count_reg < on_ticks;
            end
            on_end_reg <= running && tick && tick_count_reg == on_ticks - 16'h0001;
        end
    end

    // ==========================================
    // rail fault shutdown with optional recovery
    logic rail_fault;
    logic latched_off_reg;
    logic [1:0] sw_level;

    assign rail_fault = (ov_sync && !shutdown_reg[hs_timer_pkg::ov_dis_bit]) ||
        (uv_sync && !shutdown_reg[hs_timer_pkg::uv_dis_bit]);

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            latched_off_reg <= 1'b0;
        end else if (rail_fault && !shutdown_reg[hs_timer_pkg::rec_bit]) begin
            latched_off_reg <= 1'b1;
        end else if (wr_sw || wipe) begin
            latched_off_reg <= 1'b0;
        end
    end

    generate
        for (genvar i = 0; i < 2; i++) begin : g_sw
            always_comb begin
                unique case (switch_src_reg[i * 4 +: 3])
                    hs_timer_pkg::src_on: sw_level[i] = 1'b1;
                    hs_timer_pkg::src_first_timer: sw_level[i] = first_timer_in;
                    hs_timer_pkg::src_second_timer: sw_level[i] = timer_level_reg;
                    hs_timer_pkg::src_first_duty: sw_level[i] = first_duty_in;
                    hs_timer_pkg::src_second_duty: sw_level[i] = second_duty_in;
                    default: sw_level[i] = 1'b0;
                endcase
            end
        end
    endgenerate

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            switch_output_out <= 2'h0;
            timer_running_out <= 1'b0;
        end else begin
            switch_output_out <= (rail_fault || latched_off_reg) ? 2'h0 : sw_level;
            timer_running_out <= running;
        end
    end

    // ==========================================
    // cyclic wake sensing
    wake_filter #(
        .filter_cycles(hs_timer_pkg::filter_cycles)
    ) u_wake (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .sample_in(on_end_reg && wake_option_d_in && cyclic_sense_in),
        .level_in(wake_sync),
        .wake_out(wake_event_out)
    );

    // ==========================================
    // checks
    timer_stop_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        on_code == hs_timer_pkg::on_low |=> !timer_level_reg)
        else $error("timer level high with code zero");
    timer_high_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        on_code == hs_timer_pkg::on_high |=> timer_level_reg)
        else $error("timer level low with code six");
    reserved_zero_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (timer_cfg_reg & ~hs_timer_pkg::timer_cfg_mask) == 8'h00 &&
        (switch_src_reg & ~hs_timer_pkg::switch_src_mask) == 8'h00)
        else $error("reserved bit set");
    fault_clear_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        clear_sw[0] |=> switch_src_reg[2:0] == hs_timer_pkg::src_off)
        else $error("source not cleared on fault");
    wipe_zero_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        wipe |=> timer_cfg_reg == 8'h00 && switch_src_reg == 8'h00)
        else $error("registers not cleared");
    ov_off_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        ov_sync && !shutdown_reg[hs_timer_pkg::ov_dis_bit] |=> switch_output_out == 2'h0)
        else $error("switch on during overvoltage");
    uv_off_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        uv_sync && !shutdown_reg[hs_timer_pkg::uv_dis_bit] |=> switch_output_out == 2'h0)
        else $error("switch on during undervoltage");
    run_start_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        !uses_second_timer(switch_src_reg) |=> !timer_running_out)
        else $error("timer runs unassigned");
    period_start_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        $rose(running) |=> timer_level_reg)
        else $error("switch not on at period start");
    run_c: cover property (@(posedge clk_in) $rose(timer_running_out));
    wake_c: cover property (@(posedge clk_in) wake_event_out);
    fault_c: cover property (@(posedge clk_in) clear_sw != 2'h0);
endmodule

// ---- sim/switch_load_model.sv ----
`timescale 1ns/1ns
// ==========================================
// load on the two switch outputs
module switch_load_model (
    input wire logic clk_in,
    input wire logic [1:0] switch_output_in,
    input wire logic [1:0] short_cmd_in,
    input wire logic [1:0] heat_cmd_in,
    output logic [1:0] overcurrent_out,
    output logic [1:0] overtemp_out
);
    // a shorted or hot load only reports while it is driven
    always_ff @(posedge clk_in) begin
        overcurrent_out <= short_cmd_in & switch_output_in;
        overtemp_out <= heat_cmd_in & switch_output_in;
    end
endmodule

// ---- sim/testbench.sv ----
`timescale 1ns/1ns
module testbench;
    logic clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic [6:0] addr_in = 7'h00;
    logic [7:0] wdata_in = 8'h00;
    logic wr_in = 1'b0;
    logic rd_in = 1'b0;
    logic soft_reset_in = 1'b0;
    logic restart_entry_in = 1'b0;
    logic cyclic_sense_in = 1'b0;
    logic first_timer_in = 1'b0;
    logic first_duty_in = 1'b0;
    logic second_duty_in = 1'b0;
    logic [1:0] short_cmd = 2'h0;
    logic [1:0] heat_cmd = 2'h0;
    logic rail_ov_in = 1'b0;
    logic rail_uv_in = 1'b0;
    logic wake_option_d_in = 1'b0;
    logic wake_level_in = 1'b0;
    logic [7:0] rdata_out;
    logic [1:0] overcurrent_in;
    logic [1:0] overtemp_in;
    logic [1:0] switch_output_out;
    logic timer_running_out;
    logic wake_event_out;
    logic e;
    int miscompares = 0;
    int compares = 0;
    int n;

    always #25 clk_in = ~clk_in;

    hs_timer_ctrl uut (.clk_in(clk_in), .rst_n_in(rst_n_in), .addr_in(addr_in),
        .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
        .soft_reset_in(soft_reset_in), .restart_entry_in(restart_entry_in),
        .cyclic_sense_in(cyclic_sense_in), .first_timer_in(first_timer_in),
        .first_duty_in(first_duty_in), .second_duty_in(second_duty_in),
        .overcurrent_in(overcurrent_in), .overtemp_in(overtemp_in),
        .rail_ov_in(rail_ov_in), .rail_uv_in(rail_uv_in),
        .wake_option_d_in(wake_option_d_in), .wake_level_in(wake_level_in),
        .switch_output_out(switch_output_out), .timer_running_out(timer_running_out),
        .wake_event_out(wake_event_out));

    switch_load_model load (.clk_in(clk_in), .switch_output_in(switch_output_out),
        .short_cmd_in(short_cmd), .heat_cmd_in(heat_cmd),
        .overcurrent_out(overcurrent_in), .overtemp_out(overtemp_in));

    // ==========================================
    // reporting
    task automatic test_done;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic hang(input string what);
        miscompares++;
        $display("wrong value at %0t: %s never came", $time, what);
        test_done();
    endtask

    // ==========================================
    // register port
    task automatic reg_write(input logic [6:0] a, input logic [7:0] d);
        @(posedge clk_in);
        addr_in <= a;
        wdata_in <= d;
        wr_in <= 1'b1;
        @(posedge clk_in);
        wr_in <= 1'b0;
    endtask

    task automatic reg_read(input logic [6:0] a, input logic [7:0] exp);
        @(posedge clk_in);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge clk_in);
        rd_in <= 1'b0;
        @(negedge clk_in);
        check(rdata_out, exp, "register read");
        @(posedge clk_in);
    endtask

    task automatic settle(input int c);
        repeat (c) @(posedge clk_in);
        @(negedge clk_in);
    endtask

    task automatic check_out(input logic [1:0] exp);
        settle(6);
        check({6'h00, switch_output_out}, {6'h00, exp}, "switch outputs");
        @(posedge clk_in);
    endtask

    function automatic logic src_exp(input int code, input int s);
        case (code)
            1: return 1'b1;
            2: return s == 0;
            4: return s == 1;
            5: return s == 2;
            default: return 1'b0;
        endcase
    endfunction

    // ==========================================
    // main sequence
    initial begin
        repeat (6) @(posedge clk_in);
        rst_n_in <= 1'b1;
        reg_read(hs_timer_pkg::timer_cfg_addr, 8'h00);
        reg_read(hs_timer_pkg::switch_src_addr, 8'h00);
        reg_read(7'h20, 8'h00);
        reg_write(hs_timer_pkg::timer_cfg_addr, 8'hff);
        reg_read(hs_timer_pkg::timer_cfg_addr, 8'h77);
        reg_write(hs_timer_pkg::shutdown_addr, 8'hff);
        reg_read(hs_timer_pkg::shutdown_addr, 8'h70);
        reg_write(hs_timer_pkg::shutdown_addr, 8'h00);
        reg_write(hs_timer_pkg::switch_src_addr, 8'hff);
        reg_read(hs_timer_pkg::switch_src_addr, 8'h77);
        reg_write(hs_timer_pkg::switch_src_addr, 8'h00);
        for (int i = 0; i < 8; i++) begin
            reg_write(hs_timer_pkg::timer_cfg_addr, {1'b0, 3'(i), 1'b0, 3'(i)});
            reg_read(hs_timer_pkg::timer_cfg_addr, {1'b0, 3'(i), 1'b0, 3'(i)});
        end
        reg_write(hs_timer_pkg::timer_cfg_addr, 8'h00);
        // each source code on both switches, one external source high at a time
        for (int s = 0; s < 3; s++) begin
            first_timer_in <= (s == 0);
            first_duty_in <= (s == 1);
            second_duty_in <= (s == 2);
            for (int c = 0; c < 6; c++) begin
                reg_write(hs_timer_pkg::switch_src_addr, {1'b0, 3'((c + 1) % 6), 1'b0, 3'(c)});
                check_out({src_exp((c + 1) % 6, s), src_exp(c, s)});
            end
        end
        reg_write(hs_timer_pkg::switch_src_addr, 8'h33);
        check_out(2'b00);
        reg_write(hs_timer_pkg::timer_cfg_addr, 8'h60);
        check_out(2'b11);
        @(negedge clk_in);
        check({7'h00, timer_running_out}, 8'h00, "timer stopped");
        reg_write(hs_timer_pkg::timer_cfg_addr, 8'h00);
        check_out(2'b00);
        // supply rail faults
        reg_write(hs_timer_pkg::switch_src_addr, 8'h11);
        rail_ov_in <= 1'b1;
        check_out(2'b00);
        rail_ov_in <= 1'b0;
        check_out(2'b00);
        reg_write(hs_timer_pkg::switch_src_addr, 8'h11);
        reg_write(hs_timer_pkg::shutdown_addr, 8'h40);
        rail_ov_in <= 1'b1;
        check_out(2'b11);
        rail_ov_in <= 1'b0;
        reg_write(hs_timer_pkg::shutdown_addr, 8'h20);
        rail_uv_in <= 1'b1;
        check_out(2'b11);
        rail_uv_in <= 1'b0;
        reg_write(hs_timer_pkg::shutdown_addr, 8'h10);
        rail_uv_in <= 1'b1;
        check_out(2'b00);
        reg_read(hs_timer_pkg::fault_status_addr, 8'h10);
        rail_uv_in <= 1'b0;
        check_out(2'b11);
        reg_write(hs_timer_pkg::shutdown_addr, 8'h00);
        // load faults clear only the affected field
        short_cmd <= 2'b01;
        settle(6);
        short_cmd <= 2'b00;
        reg_read(hs_timer_pkg::switch_src_addr, 8'h10);
        heat_cmd <= 2'b10;
        settle(6);
        heat_cmd <= 2'b00;
        reg_read(hs_timer_pkg::switch_src_addr, 8'h00);
        // timed switch: shortest on-time, wake sampled at its end
        wake_option_d_in <= 1'b1;
        cyclic_sense_in <= 1'b1;
        wake_level_in <= 1'b1;
        reg_write(hs_timer_pkg::switch_src_addr, 8'h03);
        reg_write(hs_timer_pkg::timer_cfg_addr, 8'h10);
        n = 0;
        while (switch_output_out[0] !== 1'b1) begin
            @(negedge clk_in);
            n++;
            if (n > 50) hang("timed switch on");
        end
        check({7'h00, timer_running_out}, 8'h01, "timer running");
        n = 0;
        while (switch_output_out[0] === 1'b1 && n < 2100) begin
            @(negedge clk_in);
            n++;
        end
        e = (n >= 1998) && (n <= 2002);
        check({7'h00, e}, 8'h01, "on-time length");
        n = 0;
        while (wake_event_out !== 1'b1) begin
            @(negedge clk_in);
            n++;
            if (n > 1000) hang("wake event");
        end
        e = (n >= 300);
        check({7'h00, e}, 8'h01, "wake filter delay");
        reg_write(hs_timer_pkg::timer_cfg_addr, 8'h00);
        check_out(2'b00);
        @(negedge clk_in);
        check({7'h00, timer_running_out}, 8'h00, "timer stopped");
        // restart entry and soft reset, cyclic sensing still selected
        @(posedge clk_in);
        cyclic_sense_in <= 1'b1;
        reg_write(hs_timer_pkg::switch_src_addr, 8'h33);
        reg_write(hs_timer_pkg::timer_cfg_addr, 8'h12);
        @(posedge clk_in);
        restart_entry_in <= 1'b1;
        @(posedge clk_in);
        restart_entry_in <= 1'b0;
        reg_read(hs_timer_pkg::timer_cfg_addr, 8'h00);
        reg_read(hs_timer_pkg::switch_src_addr, 8'h00);
        reg_write(hs_timer_pkg::shutdown_addr, 8'h70);
        reg_write(hs_timer_pkg::timer_cfg_addr, 8'h25);
        reg_write(hs_timer_pkg::switch_src_addr, 8'h41);
        @(posedge clk_in);
        soft_reset_in <= 1'b1;
        @(posedge clk_in);
        soft_reset_in <= 1'b0;
        reg_read(hs_timer_pkg::timer_cfg_addr, 8'h00);
        reg_read(hs_timer_pkg::switch_src_addr, 8'h00);
        reg_read(hs_timer_pkg::shutdown_addr, 8'h00);
        test_done();
    end
endmodule
